// ===== hw/fllf_limit_flags.v
/*
 top of the sample buffer limit-flag block: AXI4-Lite register slave,
 flag core and the three flag interrupts. assumes the sample buffer
 strobes sit on clk and that the bus master follows AXI4-Lite.
*/
`include "fllf_defs.vh"

// Behaviour
// - the read-collision flag reads 1 when a collision was seen, else 0.
// - an enabled channel's stored sample >= upper limit sets the upper flag.
// - the upper flag clears when the buffer becomes empty.
// - an enabled channel's stored sample <= lower limit sets the lower flag.
// - the lower flag clears when the buffer becomes empty.
// - each flag interrupt sets and clears in the same cycle as its flag.
// - the upper flag reads 1 when triggered and 0 when not.
// - a read request refused because of a buffer write sets collision to 1.
// - a granted read or an empty buffer clears collision, interrupt follows.
// - the lower flag reads 1 when triggered and 0 when not.
module fllf_limit_flags #(
  parameter DATA_W = 24,
  parameter CH_W = 4
) (
  input wire clk,
  input wire srst,
  input wire sampleWrite,
  input wire [DATA_W-1:0] sampleData,
  input wire [CH_W-1:0] sampleChannel,
  input wire readRequest,
  input wire bufferEmpty,
  output reg upperLimitIrq,
  output reg lowerLimitIrq,
  output reg readCollisionIrq,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // one enable bit per channel in the enable register
  localparam NCH = 1 << CH_W;

  reg [31:0] upper_reg;
  reg [31:0] lower_reg;
  reg [31:0] chen_reg;
  reg [31:0] ctrl_reg;
  reg [4:0] awAddr_reg;
  reg awHave_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg wHave_reg;
  reg [31:0] rdata_next;
  reg rdOk;
  wire upperFlag;
  wire lowerFlag;
  wire collFlag;

  // merge byte lanes of a write into a register
  function [31:0] mergeBytes;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      mergeBytes = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          mergeBytes[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  function isMapped;
    input [4:0] a;
    begin
      isMapped = (a == `FLLF_OFS_FLAGS) || (a == `FLLF_OFS_UPPER) ||
        (a == `FLLF_OFS_LOWER) || (a == `FLLF_OFS_CHEN) ||
        (a == `FLLF_OFS_CTRL);
    end
  endfunction

  fllf_flag_core #(
    .DATA_W(DATA_W),
    .CH_W(CH_W)
  ) i_fllf_flag_core (
    .clk(clk),
    .srst(srst),
    .sampleWrite(sampleWrite),
    .sampleData(sampleData),
    .sampleChannel(sampleChannel),
    .readRequest(readRequest),
    .bufferEmpty(bufferEmpty),
    .channelLimitCheckEnable(chen_reg[NCH-1:0]),
    .upperLimitValue(upper_reg[DATA_W-1:0]),
    .lowerLimitValue(lower_reg[DATA_W-1:0]),
    .signedCompare(ctrl_reg[`FLLF_BIT_CTRL_SIGNED]),
    .upperLimitHitFlag(upperFlag),
    .lowerLimitHitFlag(lowerFlag),
    .readCollisionFlag(collFlag)
  );

  // interrupts are the flags themselves, so no extra register delay
  // software cannot clear them; only draining the buffer does, and a granted read also clears collision
  always @* begin
    upperLimitIrq = upperFlag;
    lowerLimitIrq = lowerFlag;
    readCollisionIrq = collFlag;
  end

  // the write lands once both halves are held and the previous
  // response has been taken
  wire wrFire = awHave_reg && wHave_reg && !s_axi_bvalid;

  // address and data are latched independently, in either order
  always @(posedge clk) begin
    if (srst) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= 5'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FLLF_RESP_OKAY;
      upper_reg <= `FLLF_RST_UPPER;
      lower_reg <= `FLLF_RST_LOWER;
      chen_reg <= `FLLF_RST_CHEN;
      ctrl_reg <= `FLLF_RST_CTRL;
    end else begin
      // ready pulses one cycle and stays low while a response waits,
      // so only one write is ever in flight
      s_axi_awready <= !awHave_reg && !s_axi_awready && s_axi_awvalid &&
        !s_axi_bvalid;
      s_axi_wready <= !wHave_reg && !s_axi_wready && s_axi_wvalid &&
        !s_axi_bvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(awAddr_reg) ? `FLLF_RESP_OKAY :
          `FLLF_RESP_SLVERR;
        case (awAddr_reg)
          `FLLF_OFS_UPPER: begin
            upper_reg <= mergeBytes(upper_reg, wData_reg, wStrb_reg);
          end
          `FLLF_OFS_LOWER: begin
            lower_reg <= mergeBytes(lower_reg, wData_reg, wStrb_reg);
          end
          `FLLF_OFS_CHEN: begin
            chen_reg <= mergeBytes(chen_reg, wData_reg, wStrb_reg);
          end
          `FLLF_OFS_CTRL: begin
            ctrl_reg <= mergeBytes(ctrl_reg, wData_reg, wStrb_reg);
          end
          default: begin
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // flags register is read-only; writes to it are accepted and dropped
  always @* begin
    rdata_next = 32'h00000000;
    rdOk = 1'b1;
    case (s_axi_araddr)
      `FLLF_OFS_FLAGS: begin
        rdata_next[`FLLF_BIT_READERR] = collFlag;
        rdata_next[`FLLF_BIT_UPPER] = upperFlag;
        rdata_next[`FLLF_BIT_LOWER] = lowerFlag;
      end
      `FLLF_OFS_UPPER: rdata_next = upper_reg;
      `FLLF_OFS_LOWER: rdata_next = lower_reg;
      `FLLF_OFS_CHEN: rdata_next = chen_reg;
      `FLLF_OFS_CTRL: rdata_next = ctrl_reg;
      default: rdOk = 1'b0;
    endcase
  end

  // read data is captured at the address handshake: a flag that sets
  // in that same cycle shows up on the next read
  always @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FLLF_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_next;
        s_axi_rresp <= rdOk ? `FLLF_RESP_OKAY : `FLLF_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== hw/fllf_defs.vh
/*
 holds the register offsets, field positions and reset values of the
 sample buffer limit-flag block; assumes a 32-bit AXI4-Lite slave.
*/
`ifndef FLLF_DEFS_VH
`define FLLF_DEFS_VH
`define FLLF_OFS_FLAGS 5'h00
`define FLLF_OFS_UPPER 5'h04
`define FLLF_OFS_LOWER 5'h08
`define FLLF_OFS_CHEN 5'h0c
`define FLLF_OFS_CTRL 5'h10
`define FLLF_BIT_READERR 5
`define FLLF_BIT_UPPER 4
`define FLLF_BIT_LOWER 3
`define FLLF_BIT_CTRL_SIGNED 0
`define FLLF_RST_UPPER 32'h0000ffff
`define FLLF_RST_LOWER 32'h00000000
`define FLLF_RST_CHEN 32'h00000000
`define FLLF_RST_CTRL 32'h00000000
`define FLLF_RESP_OKAY 2'h0
`define FLLF_RESP_SLVERR 2'h2
`endif

// ===== hw/fllf_flag_core.v
/*
 holds the sticky limit and read-collision flags of the sample buffer.
 assumes the buffer reports writes, read requests and emptiness as
 single-cycle, clock-synchronous strobes and levels.
*/
module fllf_flag_core #(
  parameter DATA_W = 24,
  parameter CH_W = 4
) (
  input wire clk,
  input wire srst,
  input wire sampleWrite,
  input wire [DATA_W-1:0] sampleData,
  input wire [CH_W-1:0] sampleChannel,
  input wire readRequest,
  input wire bufferEmpty,
  input wire [(1<<CH_W)-1:0] channelLimitCheckEnable,
  input wire [DATA_W-1:0] upperLimitValue,
  input wire [DATA_W-1:0] lowerLimitValue,
  input wire signedCompare,
  output reg upperLimitHitFlag,
  output reg lowerLimitHitFlag,
  output reg readCollisionFlag
);
  // a <= b, signed or unsigned as selected
  function lessEq;
    input [DATA_W-1:0] a;
    input [DATA_W-1:0] b;
    input sgn;
    begin
      if (sgn)
        lessEq = ($signed(a) <= $signed(b));
      else
        lessEq = (a <= b);
    end
  endfunction

  wire checkOn = sampleWrite && channelLimitCheckEnable[sampleChannel];
  wire upperHit = checkOn && lessEq(upperLimitValue, sampleData,
    signedCompare);
  wire lowerHit = checkOn && lessEq(sampleData, lowerLimitValue,
    signedCompare);
  // a read that lands on a write cycle is refused
  wire readRefused = readRequest && sampleWrite;
  wire readGranted = readRequest && !sampleWrite;

  // a hit in the emptying cycle wins: the sample is in the buffer again
  always @(posedge clk) begin
    if (srst) begin
      upperLimitHitFlag <= 1'b0;
      lowerLimitHitFlag <= 1'b0;
      readCollisionFlag <= 1'b0;
    end else begin
      if (upperHit)
        upperLimitHitFlag <= 1'b1;
      else if (bufferEmpty)
        upperLimitHitFlag <= 1'b0;
      if (lowerHit)
        lowerLimitHitFlag <= 1'b1;
      else if (bufferEmpty)
        lowerLimitHitFlag <= 1'b0;
      if (readRefused)
        readCollisionFlag <= 1'b1;
      else if (readGranted || bufferEmpty)
        readCollisionFlag <= 1'b0;
    end
  end
endmodule

// ===== testbench/fllf_limit_flags_monitor.sv
/* port checker of the limit-flag block, bound to its top.
 assumes one clock and a synchronous active-high reset. */
module fllf_limit_flags_monitor (
  input logic clk,
  input logic srst,
  input logic sampleWrite,
  input logic readRequest,
  input logic bufferEmpty,
  input logic upperLimitIrq,
  input logic lowerLimitIrq,
  input logic readCollisionIrq,
  input logic s_axi_arready,
  input logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_upper_clear:
    assert property (bufferEmpty && !sampleWrite |=> !upperLimitIrq)
    else $error("upper flag kept after empty");
  a_lower_clear:
    assert property (bufferEmpty && !sampleWrite |=> !lowerLimitIrq)
    else $error("lower flag kept after empty");
  a_upper_sticky:
    assert property (upperLimitIrq && !bufferEmpty |=> upperLimitIrq)
    else $error("upper flag lost");
  a_lower_sticky:
    assert property (lowerLimitIrq && !bufferEmpty |=> lowerLimitIrq)
    else $error("lower flag lost");
  a_upper_cause:
    assert property ($rose(upperLimitIrq) |-> $past(sampleWrite))
    else $error("upper flag set without a write");
  a_lower_cause:
    assert property ($rose(lowerLimitIrq) |-> $past(sampleWrite))
    else $error("lower flag set without a write");
  a_collision_set:
    assert property (readRequest && sampleWrite |=> readCollisionIrq)
    else $error("collision not flagged");
  a_collision_clear:
    assert property (readRequest && !sampleWrite |=> !readCollisionIrq)
    else $error("granted read kept collision");
  a_collision_cause:
    assert property ($rose(readCollisionIrq) |-> $past(readRequest))
    else $error("collision flag without a read");
  a_read_answer:
    assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule

bind fllf_limit_flags fllf_limit_flags_monitor i_mon (.*);

// ===== testbench/fllf_limit_flags_tb_top.sv
/* bench of the limit-flag block: bus and strobe tasks, flag tests.
 assumes the design and its checker are compiled before it. */
module fllf_limit_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, srst = 1'h1, sampleWrite = 1'h0, readRequest = 1'h0;
  logic bufferEmpty = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [23:0] sampleData = 24'h0;
  logic [3:0] sampleChannel = 4'h0, s_axi_wstrb = 4'hf;
  logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, upperLimitIrq, lowerLimitIrq, readCollisionIrq;
  int failCount = 0, testsRun = 0;

  fllf_limit_flags i_fllf_limit_flags (.*);

  always #10 clk = ~clk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'h0;
      end
    join
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask

  task rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask

  // k holds write, read request and empty, in that order
  task smp(input logic [3:0] c, input logic [23:0] d, input logic [2:0] k);
    @(posedge clk);
    {sampleWrite, readRequest, bufferEmpty} <= k;
    sampleChannel <= c;
    sampleData <= d;
    @(posedge clk);
    {sampleWrite, readRequest, bufferEmpty} <= 3'h0;
    #1;
  endtask

  task fl(input logic [2:0] e);
    chk({29'h0, upperLimitIrq, lowerLimitIrq, readCollisionIrq}, {29'h0, e});
  endtask

  task testDone;
    $display("checks %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #100000;
    failCount++;
    testDone;
  end

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    rd(5'h00, 32'h0, 2'h0);
    rd(5'h04, 32'hffff, 2'h0);
    rd(5'h14, 32'h0, 2'h2);
    wr(5'h04, 32'h100, 2'h0);
    wr(5'h08, 32'h10, 2'h0);
    wr(5'h0c, 32'h5, 2'h0);
    wr(5'h00, 32'h3f, 2'h0);
    wr(5'h14, 32'h1, 2'h2);
    rd(5'h0c, 32'h5, 2'h0);
    $display("test registers done");
    smp(4'h1, 24'h200, 3'h4);
    fl(3'h0);
    smp(4'h0, 24'hff, 3'h4);
    fl(3'h0);
    smp(4'h0, 24'h100, 3'h4);
    fl(3'h4);
    smp(4'h2, 24'h11, 3'h4);
    fl(3'h4);
    smp(4'h2, 24'h10, 3'h4);
    fl(3'h6);
    rd(5'h00, 32'h18, 2'h0);
    smp(4'h0, 24'h50, 3'h1);
    rd(5'h00, 32'h0, 2'h0);
    $display("test limits done");
    smp(4'h1, 24'h50, 3'h6);
    rd(5'h00, 32'h20, 2'h0);
    smp(4'h1, 24'h50, 3'h2);
    fl(3'h0);
    smp(4'h1, 24'h50, 3'h6);
    smp(4'h1, 24'h50, 3'h1);
    fl(3'h0);
    $display("test collision done");
    s_axi_wstrb <= 4'h2;
    wr(5'h04, 32'hffff0300, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(5'h04, 32'h300, 2'h0);
    smp(4'h0, 24'h300, 3'h5);
    fl(3'h4);
    smp(4'h0, 24'h50, 3'h1);
    fl(3'h0);
    wr(5'h08, 32'hfffff0, 2'h0);
    wr(5'h10, 32'h1, 2'h0);
    rd(5'h10, 32'h1, 2'h0);
    smp(4'h0, 24'hffffe0, 3'h4);
    fl(3'h2);
    rd(5'h00, 32'h8, 2'h0);
    smp(4'h0, 24'h50, 3'h1);
    fl(3'h0);
    $display("test modes done");
    testDone;
  end
endmodule
